// File: apfs_pkg.sv
/*
 * shared constants and types for the audio port clock and frame sync pin block:
 * register byte offsets, register layouts, reset values, pin order and pin modes.
 * assumes the register port carries 32-bit words at byte addresses, one word each.
 */
package apfs_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register byte offsets on the plain register port
    localparam logic [7:0] OFS_CTRL = 8'h00;   // audio_interface_control_register
    localparam logic [7:0] OFS_STAT = 8'h04;   // audio_interface_status_register
    localparam logic [7:0] OFS_RXCC = 8'h08;   // receive_clock_control_register
    localparam logic [7:0] OFS_TXCC = 8'h0c;   // transmit_clock_control_register
    localparam logic [7:0] OFS_MODE = 8'h10;   // pin mode, two bits per pin
    localparam logic [7:0] OFS_GOUT = 8'h14;   // general-purpose output data
    localparam logic [7:0] OFS_GIN  = 8'h18;   // general-purpose input data

    ////////////////////////////////////////////////////////////////////////////
    // pin order inside every pin vector
    localparam int unsigned PIN_HF_RX  = 0;
    localparam int unsigned PIN_HF_TX  = 1;
    localparam int unsigned PIN_FS_RX  = 2;
    localparam int unsigned PIN_FS_TX  = 3;
    localparam int unsigned PIN_BCK_RX = 4;
    localparam int unsigned NUM_PINS   = 5;

    // per-pin mode; reset leaves every pin disconnected
    typedef enum logic [1:0]
    {
        PM_OFF  = 2'h0,
        PM_IN   = 2'h1,
        PM_OUT  = 2'h2,
        PM_FUNC = 2'h3
    } apfs_pmode_type;

    // one bit per pin, rx high-frequency clock pin at bit 0
    typedef struct packed {
        logic rx_bit_clock_pin;
        logic tx_frame_sync_pin;
        logic rx_frame_sync_pin;
        logic tx_hf_clock_pin;
        logic rx_hf_clock_pin;
    } apfs_pins_type;

    ////////////////////////////////////////////////////////////////////////////
    // register layouts, bit 0 is the last field
    typedef struct packed {
        logic output_flag_one;
        logic output_flag_zero;
        logic network_mode;
        logic tx_ext_buffer_enable;
        logic sync_mode_select;
    } apfs_ctrl_type;

    typedef struct packed {
        logic hf_clock_output;
        logic rx_bit_clock_direction;
        logic rx_frame_sync_direction;
    } apfs_rxcc_type;

    typedef struct packed {
        logic hf_clock_output;
        logic tx_frame_sync_direction;
    } apfs_txcc_type;

    typedef struct packed {
        logic input_flag_one;
        logic input_flag_zero;
    } apfs_stat_type;

    ////////////////////////////////////////////////////////////////////////////
    // reset values
    localparam apfs_ctrl_type RST_CTRL = 5'h00;
    localparam apfs_rxcc_type RST_RXCC = 3'h0;
    localparam apfs_txcc_type RST_TXCC = 2'h0;
    localparam apfs_stat_type RST_STAT = 2'h0;
    localparam logic [9:0]    RST_MODE = 10'h000;
    localparam logic [4:0]    RST_GOUT = 5'h00;

endpackage : apfs_pkg

// File: apfs_clk_sel.sv
/*
 * glitch-free selector between the core clock and an external high-frequency clock.
 * assumes the external clock runs whenever it is selected or being left.
 */
module apfs_clk_sel (
    input  wire logic i_core_clk,
    input  wire logic i_ext_clk,
    input  wire logic i_rstn,
    input  wire logic i_use_ext,
    output wire logic o_clk
);

    logic core_s1_reg;
    logic core_s2_reg;
    logic core_en_reg;
    logic ext_s1_reg;
    logic ext_s2_reg;
    logic ext_en_reg;

    ////////////////////////////////////////////////////////////////////////////
    // RULE_15 break before make
    // core side: own enable only after the other side has dropped its enable
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rstn)
        begin
            core_s1_reg <= 1'b0;
            core_s2_reg <= 1'b0;
        end
        else
        begin
            core_s1_reg <= !i_use_ext && !ext_en_reg;
            core_s2_reg <= core_s1_reg;
        end
    end

    // enable changes while the clock is low, so the gate cannot clip a pulse
    always_ff @(negedge i_core_clk)
    begin
        if (!i_rstn)
            core_en_reg <= 1'b0;
        else
            core_en_reg <= core_s2_reg;
    end

    // ext side resets without its clock: the pin clock may be silent at reset
    always_ff @(posedge i_ext_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            ext_s1_reg <= 1'b0;
            ext_s2_reg <= 1'b0;
        end
        else
        begin
            ext_s1_reg <= i_use_ext && !core_en_reg;
            ext_s2_reg <= ext_s1_reg;
        end
    end

    // RULE_16 a stalled external clock would hold the handover here
    always_ff @(negedge i_ext_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            ext_en_reg <= 1'b0;
        else
            ext_en_reg <= ext_s2_reg;
    end

    // RULE_01 selected source reaches the derived clock
    assign o_clk = (i_core_clk && core_en_reg) || (i_ext_clk && ext_en_reg);

    ////////////////////////////////////////////////////////////////////////////
    chk_mux_never_both: assert property ( // RULE_15
        @(posedge i_core_clk) disable iff (!i_rstn)
        !(core_en_reg && ext_en_reg))
        else $error("both clock sources enabled at once");

    chk_mux_core_taken: assert property ( // RULE_02
        @(posedge i_core_clk) disable iff (!i_rstn)
        // the release edge itself still finds the core side in reset
        (i_rstn && !i_use_ext && !ext_en_reg) [*3] |-> core_en_reg)
        else $error("core clock not taken after three cycles");

endmodule : apfs_clk_sel

// File: apfs_pins.sv
/*
 * pin functions of the audio port clock and frame sync pins, with their registers.
 * assumes the serial core supplies frame and slot edge pulses on the link clock,
 * and that the pad ring resolves each pin from its output and low-active enable.
 */
// Decided for this implementation: the address-and-strobe port and the placing of the registers.
// How it works
// RULE_01 - rx high-frequency pin as input clocks receiver; as output drives a clock
// RULE_02 - tx high-frequency pin as input clocks transmitter; as output drives a clock
// RULE_03 - without sync mode, rx frame sync pin is the receivers' frame sync
// RULE_04 - in sync mode rx frame sync pin is flag one, or buffer enable
// RULE_05 - flag one direction follows the rx frame sync direction bit
// RULE_06 - flag one output drives the pin with the output flag one bit
// RULE_07 - flag one input lands in the input flag one status bit
// RULE_08 - flags move only at frame edges, or slot edges in network mode
// RULE_09 - in sync mode tx frame sync pin frames both directions
// RULE_10 - in async mode tx frame sync pin frames transmitters only
// RULE_11 - tx frame sync direction bit sets the tx frame sync pin direction
// RULE_12 - in general-purpose use each pin is input, output or disconnected
// RULE_13 - after reset every pin is general-purpose and disconnected
// RULE_14 - rx bit clock pin is bit clock without sync, flag zero with it
// RULE_15 - flags synchronised and clock switching free of glitches
// RULE_16 - an external high-frequency clock runs before its side is enabled
module apfs_pins #(
    parameter int unsigned DATA_W = 32
) (
    input  wire logic                   i_sys_clk,
    input  wire logic                   i_rstn,
    input  wire logic                   i_link_clk,
    input  wire logic [7:0]             i_addr,
    input  wire logic [DATA_W-1:0]      i_wdata,
    input  wire logic                   i_wr,
    input  wire logic                   i_rd,
    output wire logic [DATA_W-1:0]      o_rdata,
    input  wire logic                   i_rx_fs_out,
    input  wire logic                   i_tx_fs_out,
    input  wire logic                   i_rx_bclk_out,
    input  wire logic                   i_tx_buf_en,
    input  wire logic                   i_frame_edge,
    input  wire logic                   i_slot_edge,
    output wire logic                   o_rx_frame_sync,
    output wire logic                   o_tx_frame_sync,
    output wire logic                   o_rx_clk,
    output wire logic                   o_tx_clk,
    input  wire apfs_pkg::apfs_pins_type i_pin_in,
    output wire apfs_pkg::apfs_pins_type o_pin_out,
    output wire apfs_pkg::apfs_pins_type o_pin_oe_n
);

    if (DATA_W < 10 || DATA_W > 32)
    begin : g_bad_width
        $error("DATA_W must lie between 10 and 32");
    end

    ////////////////////////////////////////////////////////////////////////////
    // state of each clock domain
    typedef struct packed {
        apfs_pkg::apfs_ctrl_type ctrl;
        apfs_pkg::apfs_rxcc_type rxcc;
        apfs_pkg::apfs_txcc_type txcc;
        apfs_pkg::apfs_stat_type stat;
        logic [4:0][1:0]         mode;
        logic [4:0]              gout;
        logic [4:0]              gin_s1;
        logic [4:0]              gin_s2;
        logic [1:0]              if_s1;
        logic [1:0]              if_s2;
        logic [DATA_W-1:0]       rdata;
    } apfs_sys_type;

    typedef struct packed {
        logic [3:0] cfg_s1;   // sync, network, flag one, flag zero
        logic [3:0] cfg_s2;
        logic [2:0] pin_s1;   // bit clock, tx frame sync, rx frame sync
        logic [2:0] pin_s2;
        logic [1:0] oflag;
        logic [1:0] iflag;
        logic       rx_fs;
        logic       tx_fs;
    } apfs_link_type;

    localparam apfs_sys_type SYS_RST = '{
        ctrl:    apfs_pkg::RST_CTRL,
        rxcc:    apfs_pkg::RST_RXCC,
        txcc:    apfs_pkg::RST_TXCC,
        stat:    apfs_pkg::RST_STAT,
        mode:    apfs_pkg::RST_MODE,
        gout:    apfs_pkg::RST_GOUT,
        default: '0
    };

    apfs_sys_type  s_reg;
    apfs_sys_type  s_next;
    apfs_link_type l_reg;
    apfs_link_type l_next;
    logic          lrst_s1_reg;
    logic          lrst_s2_reg;
    logic          l_bnd;
    logic [4:0]    func;
    logic [4:0]    fv;
    logic [4:0]    fd;
    logic [4:0]    pin_val;
    logic [4:0]    pin_oe_n;
    logic [1:0]    flag_in;
    logic [1:0]    use_ext;
    logic          rx_clk;
    logic          tx_clk;
    logic          sync;

    assign sync = s_reg.ctrl.sync_mode_select;

    ////////////////////////////////////////////////////////////////////////////
    // register port and system-side state
    always_comb
    begin
        s_next       = s_reg;
        s_next.rdata = '0;   // read data stand one cycle only
        // pin levels come from outside, two flops before use
        s_next.gin_s1 = i_pin_in;
        s_next.gin_s2 = s_reg.gin_s1;
        // flags sampled on the link clock cross back as levels
        s_next.if_s1 = l_reg.iflag;
        s_next.if_s2 = s_reg.if_s1;
        // RULE_07 input flag into status
        if (flag_in[1])
            s_next.stat.input_flag_one = s_reg.if_s2[1];
        if (flag_in[0])
            s_next.stat.input_flag_zero = s_reg.if_s2[0];
        if (i_wr)
        begin
            if (i_addr == apfs_pkg::OFS_CTRL)
                s_next.ctrl = i_wdata[4:0];
            else if (i_addr == apfs_pkg::OFS_RXCC)
                s_next.rxcc = i_wdata[2:0];
            else if (i_addr == apfs_pkg::OFS_TXCC)
                s_next.txcc = i_wdata[1:0];
            else if (i_addr == apfs_pkg::OFS_MODE)
                s_next.mode = i_wdata[9:0];
            else if (i_addr == apfs_pkg::OFS_GOUT)
                s_next.gout = i_wdata[4:0];
        end
        if (i_rd)
        begin
            if (i_addr == apfs_pkg::OFS_CTRL)
                s_next.rdata = DATA_W'(s_reg.ctrl);
            else if (i_addr == apfs_pkg::OFS_STAT)
                s_next.rdata = DATA_W'(s_reg.stat);
            else if (i_addr == apfs_pkg::OFS_RXCC)
                s_next.rdata = DATA_W'(s_reg.rxcc);
            else if (i_addr == apfs_pkg::OFS_TXCC)
                s_next.rdata = DATA_W'(s_reg.txcc);
            else if (i_addr == apfs_pkg::OFS_MODE)
                s_next.rdata = DATA_W'(s_reg.mode);
            else if (i_addr == apfs_pkg::OFS_GOUT)
                s_next.rdata = DATA_W'(s_reg.gout);
            else if (i_addr == apfs_pkg::OFS_GIN)
                s_next.rdata = DATA_W'(s_reg.gin_s2 & gin_mask());
        end
    end

    // input pins read back only where set as inputs; disconnected pins read zero
    function automatic logic [4:0] gin_mask();
        logic [4:0] m;
        m = '0;
        for (int i = 0; i < apfs_pkg::NUM_PINS; i++)
            m[i] = (s_reg.mode[i] == apfs_pkg::PM_IN);
        return m;
    endfunction : gin_mask

    // RULE_13 reset to disconnected
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rstn)
            s_reg <= SYS_RST;
        else
            s_reg <= s_next;
    end

    ////////////////////////////////////////////////////////////////////////////
    // link-side reset release, then flag and frame sync logic
    always_ff @(posedge i_link_clk)
    begin
        lrst_s1_reg <= i_rstn;
        lrst_s2_reg <= lrst_s1_reg;
    end

    // RULE_08 boundary choice
    assign l_bnd = l_reg.cfg_s2[2] ? i_slot_edge : i_frame_edge;

    always_comb
    begin
        l_next        = l_reg;
        // RULE_15 settings and pins pass two flops
        l_next.cfg_s1 = {sync, s_reg.ctrl.network_mode,
                         s_reg.ctrl.output_flag_one, s_reg.ctrl.output_flag_zero};
        l_next.cfg_s2 = l_reg.cfg_s1;
        l_next.pin_s1 = {i_pin_in.rx_bit_clock_pin, i_pin_in.tx_frame_sync_pin,
                         i_pin_in.rx_frame_sync_pin};
        l_next.pin_s2 = l_reg.pin_s1;
        // RULE_06 output flags move at the boundary only
        if (l_bnd)
        begin
            l_next.oflag = l_reg.cfg_s2[1:0];
            l_next.iflag = {l_reg.pin_s2[0], l_reg.pin_s2[2]};
        end
        // RULE_09 sync mode frames receivers from tx pin
        // RULE_10 async mode keeps them apart
        l_next.tx_fs = l_reg.pin_s2[1];
        l_next.rx_fs = l_reg.cfg_s2[3] ? l_reg.pin_s2[1] : l_reg.pin_s2[0];
    end

    always_ff @(posedge i_link_clk)
    begin
        if (!lrst_s2_reg)
            l_reg <= '0;
        else
            l_reg <= l_next;
    end

    assign o_rx_frame_sync = l_reg.rx_fs;
    assign o_tx_frame_sync = l_reg.tx_fs;

    ////////////////////////////////////////////////////////////////////////////
    // clock source selection for both sides
    always_comb
    begin
        func = '0;
        for (int i = 0; i < apfs_pkg::NUM_PINS; i++)
            func[i] = (s_reg.mode[i] == apfs_pkg::PM_FUNC);
        // RULE_01 external clock when pin is input
        use_ext[0] = func[apfs_pkg::PIN_HF_RX] && !s_reg.rxcc.hf_clock_output;
        // RULE_02 external clock when pin is input
        use_ext[1] = func[apfs_pkg::PIN_HF_TX] && !s_reg.txcc.hf_clock_output;
        // RULE_05 flag one is input while its direction bit is clear
        flag_in[1] = func[apfs_pkg::PIN_FS_RX] && sync
                     && !s_reg.ctrl.tx_ext_buffer_enable
                     && !s_reg.rxcc.rx_frame_sync_direction;
        flag_in[0] = func[apfs_pkg::PIN_BCK_RX] && sync
                     && !s_reg.rxcc.rx_bit_clock_direction;
    end

    apfs_clk_sel u_rx_clk (
        .i_core_clk (i_sys_clk),
        .i_ext_clk  (i_pin_in.rx_hf_clock_pin),
        .i_rstn     (i_rstn),
        .i_use_ext  (use_ext[0]),
        .o_clk      (rx_clk)
    );

    apfs_clk_sel u_tx_clk (
        .i_core_clk (i_sys_clk),
        .i_ext_clk  (i_pin_in.tx_hf_clock_pin),
        .i_rstn     (i_rstn),
        .i_use_ext  (use_ext[1]),
        .o_clk      (tx_clk)
    );

    assign o_rx_clk = rx_clk;
    assign o_tx_clk = tx_clk;

    ////////////////////////////////////////////////////////////////////////////
    // audio function value and drive of each pin
    always_comb
    begin
        fv = '0;
        fd = '0;
        // RULE_01 output drives the sample clock
        fv[apfs_pkg::PIN_HF_RX] = rx_clk;
        fd[apfs_pkg::PIN_HF_RX] = s_reg.rxcc.hf_clock_output;
        // RULE_02 output drives the sample clock
        fv[apfs_pkg::PIN_HF_TX] = tx_clk;
        fd[apfs_pkg::PIN_HF_TX] = s_reg.txcc.hf_clock_output;
        // RULE_04 frame sync, flag one or buffer enable
        fd[apfs_pkg::PIN_FS_RX] = s_reg.rxcc.rx_frame_sync_direction;
        if (!sync)
            fv[apfs_pkg::PIN_FS_RX] = i_rx_fs_out;   // RULE_03 receivers' frame sync
        else if (!s_reg.ctrl.tx_ext_buffer_enable)
            fv[apfs_pkg::PIN_FS_RX] = l_reg.oflag[1];
        else
            fv[apfs_pkg::PIN_FS_RX] = i_tx_buf_en;
        // RULE_11 direction from its bit
        fv[apfs_pkg::PIN_FS_TX] = i_tx_fs_out;
        fd[apfs_pkg::PIN_FS_TX] = s_reg.txcc.tx_frame_sync_direction;
        // RULE_14 bit clock or flag zero
        fd[apfs_pkg::PIN_BCK_RX] = s_reg.rxcc.rx_bit_clock_direction;
        fv[apfs_pkg::PIN_BCK_RX] = sync ? l_reg.oflag[0] : i_rx_bclk_out;
    end

    // RULE_12 general-purpose fallback per pin
    for (genvar i = 0; i < apfs_pkg::NUM_PINS; i++)
    begin : g_pin
        assign pin_val[i]  = func[i] ? fv[i] : s_reg.gout[i];
        assign pin_oe_n[i] = func[i] ? !fd[i] : (s_reg.mode[i] != apfs_pkg::PM_OUT);
    end

    assign o_pin_out  = pin_val;
    assign o_pin_oe_n = pin_oe_n;
    assign o_rdata    = s_reg.rdata;

    ////////////////////////////////////////////////////////////////////////////
    // checks on the system clock
    chk_reset_pins_off: assert property ( // RULE_13
        @(posedge i_sys_clk) disable iff (!i_rstn)
        $rose(i_rstn) |-> (&o_pin_oe_n) && (s_reg.mode == '0))
        else $error("pin driven right after reset");

    chk_gpio_out_drive: assert property ( // RULE_12
        @(posedge i_sys_clk) disable iff (!i_rstn)
        (i_wr && i_addr == apfs_pkg::OFS_GOUT
         && s_reg.mode[apfs_pkg::PIN_FS_TX] == apfs_pkg::PM_OUT)
        |=> !o_pin_oe_n.tx_frame_sync_pin
            && o_pin_out.tx_frame_sync_pin == $past(i_wdata[3]))
        else $error("general-purpose output not driven");

    chk_fsr_async_sync: assert property ( // RULE_03
        @(posedge i_sys_clk) disable iff (!i_rstn)
        (func[apfs_pkg::PIN_FS_RX] && !sync && s_reg.rxcc.rx_frame_sync_direction)
        |-> !o_pin_oe_n.rx_frame_sync_pin && o_pin_out.rx_frame_sync_pin == i_rx_fs_out)
        else $error("rx frame sync not driven from receivers");

    chk_fsr_buffer_en: assert property ( // RULE_04
        @(posedge i_sys_clk) disable iff (!i_rstn)
        (func[apfs_pkg::PIN_FS_RX] && sync && s_reg.ctrl.tx_ext_buffer_enable
         && s_reg.rxcc.rx_frame_sync_direction)
        |-> o_pin_out.rx_frame_sync_pin == i_tx_buf_en)
        else $error("buffer enable not on rx frame sync pin");

    chk_flag_one_dir: assert property ( // RULE_05
        @(posedge i_sys_clk) disable iff (!i_rstn)
        (i_wr && i_addr == apfs_pkg::OFS_RXCC && func[apfs_pkg::PIN_FS_RX] && sync)
        |=> o_pin_oe_n.rx_frame_sync_pin == !$past(i_wdata[0]))
        else $error("flag one direction wrong");

    chk_fst_direction: assert property ( // RULE_11
        @(posedge i_sys_clk) disable iff (!i_rstn)
        (i_wr && i_addr == apfs_pkg::OFS_TXCC && func[apfs_pkg::PIN_FS_TX])
        |=> o_pin_oe_n.tx_frame_sync_pin == !$past(i_wdata[0]))
        else $error("tx frame sync direction wrong");

    chk_bck_async_out: assert property ( // RULE_14
        @(posedge i_sys_clk) disable iff (!i_rstn)
        (func[apfs_pkg::PIN_BCK_RX] && !sync && s_reg.rxcc.rx_bit_clock_direction)
        |-> o_pin_out.rx_bit_clock_pin == i_rx_bclk_out)
        else $error("rx bit clock not passed out");

    ////////////////////////////////////////////////////////////////////////////
    // checks on the link clock
    chk_oflag_update: assert property ( // RULE_06
        @(posedge i_link_clk) disable iff (!lrst_s2_reg)
        l_bnd |=> l_reg.oflag[1] == $past(l_reg.cfg_s2[1]))
        else $error("output flag one not taken at boundary");

    chk_iflag_sample: assert property ( // RULE_07
        @(posedge i_link_clk) disable iff (!lrst_s2_reg)
        l_bnd |=> l_reg.iflag[1] == $past(l_reg.pin_s2[0]))
        else $error("input flag one not sampled at boundary");

    chk_flag_hold: assert property ( // RULE_08
        @(posedge i_link_clk) disable iff (!lrst_s2_reg)
        (!l_bnd && lrst_s2_reg) |=> $stable(l_reg.oflag) && $stable(l_reg.iflag))
        else $error("flag moved between boundaries");

    chk_sync_frame: assert property ( // RULE_09
        @(posedge i_link_clk) disable iff (!lrst_s2_reg)
        l_reg.cfg_s2[3] |=> o_rx_frame_sync == $past(l_reg.pin_s2[1]))
        else $error("receivers not framed from tx pin");

    chk_async_frame: assert property ( // RULE_10
        @(posedge i_link_clk) disable iff (!lrst_s2_reg)
        !l_reg.cfg_s2[3] |=> o_rx_frame_sync == $past(l_reg.pin_s2[0])
                             && o_tx_frame_sync == $past(l_reg.pin_s2[1]))
        else $error("async frame syncs mixed");

endmodule : apfs_pins

// File: apfs_far.sv
/*
 * far-side model: codecs and a clock source on the five audio port pins.
 * assumes the device's low-active enable marks the pins it drives.
 */
module apfs_far (
    input  wire logic                    i_hf_clk,
    input  wire logic [1:0]              i_fs_lvl,
    input  wire logic [1:0]              i_fs_drv,
    input  wire apfs_pkg::apfs_pins_type i_dev_out,
    input  wire apfs_pkg::apfs_pins_type i_dev_oe_n,
    output logic [4:0]                   o_wire
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [4:0] far_v;
    ////////////////////////////////////////////////////////////////////////
    // clock runs continuously
    // released frame sync lines and the bit clock line fall to their pull-downs
    assign far_v = {1'b0, i_fs_drv & i_fs_lvl, i_hf_clk, i_hf_clk};
    // the device wins wherever it drives
    assign o_wire = (~i_dev_oe_n & i_dev_out) | (i_dev_oe_n & far_v);
endmodule : apfs_far

// File: tb_top.sv
/*
 * random and corner-case bench for the audio port pin block.
 * assumes the far-side model resolves every pin wire.
 */
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 0, lclk = 0, hclk = 0, rstn = 0, wr_s = 0, rd_s = 0, fe = 0, se = 0;
    logic rfo = 0, tfo = 0, bco = 0, tbe = 0, rxc, txc, orfs, otfs;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000, rdata, r;
    logic [1:0]  fl = 2'h0, fd = 2'h0;
    logic [4:0]  pw, v;
    apfs_pkg::apfs_pins_type pout, oe_n;
    int bad_count = 0, n_tests = 0, tmo = 0, nrx = 0, ntx = 0;
    // core 100 ns, link 125 ns off phase, external hf source much faster than core
    always #50 clk = ~clk;
    always #62.5 lclk = ~lclk;
    always #15 hclk = ~hclk;
    always @(posedge rxc) nrx++;
    always @(posedge txc) ntx++;
    apfs_pins u_apfs_pins (.i_sys_clk(clk), .i_rstn(rstn), .i_link_clk(lclk), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr_s), .i_rd(rd_s), .o_rdata(rdata), .i_rx_fs_out(rfo),
        .i_tx_fs_out(tfo), .i_rx_bclk_out(bco), .i_tx_buf_en(tbe), .i_frame_edge(fe),
        .i_slot_edge(se), .o_rx_frame_sync(orfs), .o_tx_frame_sync(otfs), .o_rx_clk(rxc),
        .o_tx_clk(txc), .i_pin_in(pw), .o_pin_out(pout), .o_pin_oe_n(oe_n));
    apfs_far u_apfs_far (.i_hf_clk(hclk), .i_fs_lvl(fl), .i_fs_drv(fd), .i_dev_out(pout),
        .i_dev_oe_n(oe_n), .o_wire(pw));
    ////////////////////////////////////////////////////////////////////////
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : test_done
    // hang guard, the run needs a few hundred cycles
    always @(posedge clk)
    begin
        tmo++;
        if (tmo == 20000)
        begin
            bad_count++;
            test_done();
        end
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        n_tests++;
        if (s !== e)
        begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask : wr
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        @(negedge clk);
        r = rdata;
    endtask : rd
    // control reaches the link side two flops late, so wait before the boundary
    task automatic step(input logic [31:0] c, input int kind);
        wr(8'h00, c);
        repeat (6) @(posedge lclk);
        fe <= (kind == 0);
        se <= (kind == 1);
        @(posedge lclk);
        fe <= 1'b0;
        se <= 1'b0;
        repeat (3) @(posedge lclk);
        @(negedge clk);
    endtask : step
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        void'($urandom(32'h47da8281));
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        @(negedge clk);
        chk("reset_oe", 32'h1f, oe_n);
        rd(8'h10);
        chk("reset_mode", 0, r);
        rd(8'h1c);
        chk("unmapped", 0, r);
        v = 5'($urandom);
        fl <= 2'($urandom);
        wr(8'h10, 32'h0000_02aa);
        wr(8'h14, {27'h0, v});
        @(negedge clk);
        chk("gpio_out", v, pout);
        chk("gpio_out_oe", 0, oe_n);
        fd <= 2'h3;
        wr(8'h10, 32'h0000_0155);
        repeat (4) @(posedge clk);
        rd(8'h18);
        chk("gpio_in", {fl, 2'h0}, r & 32'h1c);
        chk("gpio_in_oe", 32'h1f, oe_n);
        $display("end gpio");
        wr(8'h10, 32'h0000_03ff);
        wr(8'h08, 32'h0000_0001);
        for (int k = 0; k < 4; k++)
        begin
            {rfo, tfo, tbe} <= 3'($urandom);
            wr(8'h0c, k % 2);
            wr(8'h00, k < 2 ? 0 : 3);
            @(negedge clk);
            chk("rx_fs_pin", k < 2 ? rfo : tbe, pout[2]);
            chk("rx_fs_oe", 0, oe_n[2]);
            chk("tx_fs_oe", (k % 2) ? 0 : 1, oe_n[3]);
            if (k % 2)
                chk("tx_fs_pin", tfo, pout[3]);
        end
        wr(8'h08, 32'h0000_0004);
        wr(8'h0c, 32'h0000_0002);
        repeat (10) @(posedge clk);
        chk("hf_out_oe", 0, oe_n[1:0]);
        wr(8'h08, 0);
        wr(8'h0c, 0);
        repeat (10) @(posedge clk);
        nrx = 0;
        ntx = 0;
        repeat (10) @(posedge clk);
        chk("hf_source", 1, nrx > 25 && ntx > 25);
        $display("end pin functions");
        fd <= 2'h0;
        wr(8'h08, 32'h0000_0001);
        step(32'h0000_0011, 0);
        chk("flag_set", 1, pout[2]);
        step(32'h0000_0001, 2);
        chk("flag_hold", 1, pout[2]);
        step(32'h0000_0005, 0);
        chk("flag_net_frame", 1, pout[2]);
        step(32'h0000_0005, 1);
        chk("flag_net_slot", 0, pout[2]);
        wr(8'h08, 0);
        fl <= 2'h3;
        fd <= 2'h3;
        step(32'h0000_0001, 0);
        chk("flag_in_oe", 1, oe_n[2]);
        repeat (5) @(posedge clk);
        rd(8'h04);
        chk("flag_in", 2, r & 32'h2);
        $display("end flags");
        fl <= 2'h2;
        repeat (5) @(posedge lclk);
        @(negedge clk);
        chk("sync_rx_fs", 1, orfs);
        wr(8'h00, 0);
        repeat (5) @(posedge lclk);
        @(negedge clk);
        chk("async_rx_fs", 0, orfs);
        chk("async_tx_fs", 1, otfs);
        $display("end frame sync");
        bco <= 1'b1;
        wr(8'h08, 32'h0000_0002);
        @(negedge clk);
        chk("rx_bck_pin", 1, pout[4]);
        bco <= 1'b0;
        step(32'h0000_0009, 0);
        chk("flag_zero", 1, pout[4]);
        $display("end bit clock");
        test_done();
    end
endmodule : tb_top
